// ==== core/remote_unit_command_decoder.sv ====
// Transmission code decoder and status word keeper of the remote unit
`timescale 1ns/1ns
module remote_unit_command_decoder
    import remote_unit_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        code_valid,
    input  wire logic [7:0]  code_word,
    input  wire logic        addr_ok,
    input  wire logic        addr_invalid,
    input  wire logic        code_invalid,
    input  wire logic        parity_err,
    input  wire logic        data_valid,
    input  wire logic [7:0]  data_word,
    input  wire logic        msg_end,
    input  wire logic        encode_ok,
    input  wire logic [7:0]  chan_rd_data,
    input  wire logic        rx_a,
    input  wire logic        rx_b,
    input  wire logic        tx_a,
    input  wire logic        tx_b,
    output logic             rom_start,
    output logic [6:0]       rom_addr,
    output logic             mem_start,
    output logic             mem_to_ctrl,
    output logic             chan_wr,
    output logic [12:0]      chan_addr,
    output logic [7:0]       chan_data,
    output logic             reply_valid,
    output logic [7:0]       reply_word,
    output logic [7:0]       status_word
);

    logic [3:0]   act_meta;
    logic [3:0]   act_sync;
    rx_state_type state;
    rx_state_type next_state;
    cmd_type      kind;
    cmd_type      next_kind;
    logic [7:0]   code_reg;
    logic [7:0]   next_code_reg;
    logic [1:0]   word_cnt;
    logic [1:0]   next_word_cnt;
    logic [7:0]   operand;
    logic [7:0]   next_operand;
    logic [7:0]   cur_data;
    logic [7:0]   next_cur_data;
    logic [7:0]   last_data;
    logic [7:0]   next_last_data;
    logic [2:0]   err_pend;
    logic [2:0]   next_err_pend;
    logic [2:0]   err_now;
    logic         ending;
    logic         next_rom_start;
    logic [6:0]   next_rom_addr;
    logic         next_mem_start;
    logic         next_mem_to_ctrl;
    logic         next_chan_wr;
    logic [12:0]  next_chan_addr;
    logic [7:0]   next_chan_data;
    logic         next_reply_valid;
    logic [7:0]   next_reply_word;
    logic [7:0]   next_status;

    // Modem activity pins come from outside; two flops before use
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_meta <= 4'h0;
            act_sync <= 4'h0;
        end else begin
            act_meta <= {rx_a, rx_b, tx_a, tx_b};
            act_sync <= act_meta;
        end
    end

    // Errors seen in this message so far, including this cycle
    assign err_now = err_pend | {parity_err, addr_invalid, code_invalid & code_valid};
    assign ending  = (state == ST_BODY) && msg_end;

    // Message decode, command execution and status keeping
    always_comb begin
        next_state       = state;
        next_kind        = kind;
        next_code_reg    = code_reg;
        next_word_cnt    = word_cnt;
        next_operand     = operand;
        next_cur_data    = cur_data;
        next_last_data   = last_data;
        next_err_pend    = err_now;
        next_rom_start   = 1'b0;
        next_rom_addr    = rom_addr;
        next_mem_start   = 1'b0;
        next_mem_to_ctrl = mem_to_ctrl;
        next_chan_wr     = 1'b0;
        next_chan_addr   = chan_addr;
        next_chan_data   = chan_data;
        next_reply_valid = 1'b0;
        next_reply_word  = reply_word;
        next_status      = status_word;
        unique case (state)
            ST_IDLE: begin
                if (code_valid && addr_ok) begin
                    next_state    = ST_BODY;
                    next_code_reg = code_word;
                    next_word_cnt = 2'h0;
                    if (!code_word[CODE_MODE_HI]) begin
                        // Normal mode: remaining bits start the program
                        next_rom_start = 1'b1;
                        next_rom_addr  = code_word[6:0];
                        // Common codes decode alike in every unit
                        unique case (code_word)
                            CODE_NOP:    next_kind = CMD_NOP;
                            CODE_MODIFY: next_kind = CMD_MODIFY;
                            CODE_XMIT:   next_kind = CMD_XMIT;
                            CODE_TURN:   next_kind = CMD_TURN;
                            default:     next_kind = CMD_NORMAL;
                        endcase
                    end else if (!code_word[CODE_MODE_LO]) begin
                        next_kind = CMD_OVR;
                    end else begin
                        // Memory access; bits 4-8 are ignored
                        next_kind        = CMD_MEM;
                        next_mem_start   = 1'b1;
                        next_mem_to_ctrl = code_word[CODE_DIR];
                    end
                end
            end
            ST_BODY: begin
                if (data_valid) begin
                    if (word_cnt == 2'h0) begin
                        next_operand = data_word;
                    end
                    next_cur_data = data_word;
                    if (word_cnt != 2'h3) begin
                        next_word_cnt = word_cnt + 2'h1;
                    end
                end
                if (msg_end) begin
                    next_state = ST_IDLE;
                    unique case (kind)
                        CMD_MODIFY: begin
                            if (encode_ok && word_cnt != 2'h0) begin
                                next_status = operand;
                            end
                        end
                        CMD_XMIT: begin
                            if (encode_ok) begin
                                next_reply_valid = 1'b1;
                                next_reply_word  = status_word;
                            end
                        end
                        CMD_TURN: begin
                            next_reply_valid = 1'b1;
                            next_reply_word  = last_data;
                        end
                        CMD_OVR: begin
                            // Read needs one word, write two or more; channel from code and first word
                            next_chan_addr = {code_reg[4:0], operand};
                            if (encode_ok && code_reg[CODE_DIR] && word_cnt != 2'h0) begin
                                next_reply_valid = 1'b1;
                                next_reply_word  = chan_rd_data;
                            end else if (encode_ok && word_cnt >= 2'h2) begin
                                next_chan_wr   = 1'b1;
                                next_chan_data = cur_data;
                            end
                        end
                        default: begin
                            // No-op and other normal codes never answer
                            next_reply_valid = 1'b0;
                        end
                    endcase
                    if (word_cnt != 2'h0) begin
                        next_last_data = cur_data;
                    end
                end
            end
        endcase
        // Errors of the message just ended are reported by the next one
        if (ending || (msg_end && state == ST_IDLE)) begin
            next_err_pend = 3'h0;
            if (ending && kind == CMD_MODIFY && encode_ok && word_cnt != 2'h0) begin
                next_status[ST_PARITY:ST_CODE] = next_status[ST_PARITY:ST_CODE] | err_now;
            end else begin
                next_status[ST_PARITY:ST_CODE] = err_now;
            end
        end
        // Modem activity bits are sticky; activity wins over a load
        next_status[ST_RX_A:ST_TX_B] = next_status[ST_RX_A:ST_TX_B] | act_sync;
    end

    // State registers; status takes its power-on pattern here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= ST_IDLE;
            kind        <= CMD_NORMAL;
            code_reg    <= 8'h00;
            word_cnt    <= 2'h0;
            operand     <= 8'h00;
            cur_data    <= 8'h00;
            last_data   <= 8'h00;
            err_pend    <= 3'h0;
            rom_start   <= 1'b0;
            rom_addr    <= 7'h00;
            mem_start   <= 1'b0;
            mem_to_ctrl <= 1'b0;
            chan_wr     <= 1'b0;
            chan_addr   <= 13'h0000;
            chan_data   <= 8'h00;
            reply_valid <= 1'b0;
            reply_word  <= 8'h00;
            status_word <= STATUS_RESET;
        end else begin
            state       <= next_state;
            kind        <= next_kind;
            code_reg    <= next_code_reg;
            word_cnt    <= next_word_cnt;
            operand     <= next_operand;
            cur_data    <= next_cur_data;
            last_data   <= next_last_data;
            err_pend    <= next_err_pend;
            rom_start   <= next_rom_start;
            rom_addr    <= next_rom_addr;
            mem_start   <= next_mem_start;
            mem_to_ctrl <= next_mem_to_ctrl;
            chan_wr     <= next_chan_wr;
            chan_addr   <= next_chan_addr;
            chan_data   <= next_chan_data;
            reply_valid <= next_reply_valid;
            reply_word  <= next_reply_word;
            status_word <= next_status;
        end
    end

    // Checks on decode and status behaviour
    a_mem_select: assert property (@(posedge core_clk) disable iff (!rst_n)
        mem_start |-> $past(code_valid && addr_ok && code_word[7:6] == 2'b11 && state == ST_IDLE))
        else $error("memory access started without an 11 code");
    a_mem_direction: assert property (@(posedge core_clk) disable iff (!rst_n)
        mem_start |-> mem_to_ctrl == $past(code_word[CODE_DIR]))
        else $error("memory access direction differs from code bit 3");
    a_normal_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == ST_IDLE && code_valid && addr_ok && !code_word[7])
        |=> rom_start && rom_addr == $past(code_word[6:0]))
        else $error("normal mode start location wrong");
    a_nop_silent: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ending && kind == CMD_NOP) |=> !reply_valid)
        else $error("reply sent for no-operation code");
    a_modify_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ending && kind == CMD_MODIFY && encode_ok && word_cnt != 2'h0)
        |=> status_word[ST_SPARE] == $past(operand[ST_SPARE]))
        else $error("status not loaded by modify command");
    a_xmit_status: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ending && kind == CMD_XMIT && encode_ok)
        |=> reply_valid && reply_word == $past(status_word))
        else $error("status word not returned");
    a_turn_echo: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ending && kind == CMD_TURN) |=> reply_valid && reply_word == $past(last_data))
        else $error("turnaround did not echo last data");
    a_modem_activity: assert property (@(posedge core_clk) disable iff (!rst_n)
        act_sync[3] |=> status_word[ST_RX_A])
        else $error("modem A receive activity not flagged");
    a_error_report: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ending || (msg_end && state == ST_IDLE))
        |=> (status_word[ST_PARITY:ST_CODE] & $past(err_now)) == $past(err_now))
        else $error("message error not latched into status");
    a_power_pattern: assert property (@(posedge core_clk)
        $rose(rst_n) |-> status_word == STATUS_RESET)
        else $error("status power-on pattern wrong");
    a_override_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        chan_wr |-> !reply_valid && chan_addr == {$past(code_reg[4:0]), $past(operand)})
        else $error("override write with wrong channel");

endmodule // remote_unit_command_decoder

// ==== core/remote_unit_pkg.sv ====
// Constants, code words and types for the remote unit command decoder
package remote_unit_pkg;

    // Transmission code fields; bit 1 of the word is the MSB
    localparam int unsigned CODE_MODE_HI = 7;
    localparam int unsigned CODE_MODE_LO = 6;
    localparam int unsigned CODE_DIR     = 5;

    // Common normal-mode codes
    localparam logic [7:0] CODE_NOP    = 8'h00;
    localparam logic [7:0] CODE_MODIFY = 8'h01;
    localparam logic [7:0] CODE_XMIT   = 8'h06;
    localparam logic [7:0] CODE_TURN   = 8'h0d;

    // Status word bit positions; bit 1 of the word is the MSB
    localparam int unsigned ST_RX_A   = 7;
    localparam int unsigned ST_RX_B   = 6;
    localparam int unsigned ST_TX_A   = 5;
    localparam int unsigned ST_TX_B   = 4;
    localparam int unsigned ST_PARITY = 3;
    localparam int unsigned ST_ADDR   = 2;
    localparam int unsigned ST_CODE   = 1;
    localparam int unsigned ST_SPARE  = 0;

    // Power-on status pattern 11100000
    localparam logic [7:0] STATUS_RESET = 8'he0;

    // Message reception states
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BODY = 1'b1
    } rx_state_type;

    // Command kinds taken from the transmission code
    typedef enum logic [2:0] {
        CMD_NORMAL = 3'h0,
        CMD_NOP    = 3'h1,
        CMD_MODIFY = 3'h2,
        CMD_XMIT   = 3'h3,
        CMD_TURN   = 3'h4,
        CMD_OVR    = 3'h5,
        CMD_MEM    = 3'h6
    } cmd_type;

endpackage

// ==== testbench/bus_control_unit_model.sv ====
// Behavioural bus control unit that issues command messages to the remote unit
`timescale 1ns/1ns
module bus_control_unit_model (
    input  wire logic       core_clk,
    output logic            code_valid,
    output logic [7:0]      code_word,
    output logic            addr_ok,
    output logic            addr_invalid,
    output logic            code_invalid,
    output logic            parity_err,
    output logic            data_valid,
    output logic [7:0]      data_word,
    output logic            msg_end,
    output logic            encode_ok
);
    // Quiet bus at time zero
    initial begin
        {code_valid, addr_ok, addr_invalid, code_invalid, parity_err} = 5'h00;
        {data_valid, msg_end, encode_ok, code_word, data_word} = 19'h00000;
    end

    // One message; f = {addressed, code bad, parity bad, address bad, encoding good}
    task automatic send(input logic [7:0] c, input logic [4:0] f, input int n,
                        input logic [7:0] w0, input logic [7:0] w1);
        @(posedge core_clk);
        code_valid <= 1'b1;
        code_word <= c;
        {addr_ok, code_invalid} <= f[4:3];
        @(posedge core_clk);
        // Released code lines show the inverse, errors flagged in a gap cycle
        code_valid <= 1'b0;
        code_word <= ~c;
        {addr_ok, code_invalid} <= ~f[4:3];
        {parity_err, addr_invalid} <= f[2:1];
        // Sends n data words for any code: w0 first, then w1 for every later word
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            {parity_err, addr_invalid} <= 2'b00;
            data_valid <= 1'b1;
            data_word <= (i == 0) ? w0 : w1;
        end
        @(posedge core_clk);
        // End of message; no reply is awaited here, for a no-op least of all
        {parity_err, addr_invalid, data_valid} <= 3'b000;
        data_word <= ~data_word;
        msg_end <= 1'b1;
        encode_ok <= f[0];
        @(posedge core_clk);
        msg_end <= 1'b0;
        encode_ok <= ~f[0];
    endtask
endmodule // bus_control_unit_model

// ==== testbench/remote_unit_command_decoder_tb.sv ====
// Self-checking bench for the remote unit command decoder
`timescale 1ns/1ns
module remote_unit_command_decoder_tb;
    logic        core_clk, rst_n, code_valid, addr_ok, addr_invalid, code_invalid;
    logic        parity_err, data_valid, msg_end, encode_ok, rx_a, rx_b, tx_a, tx_b;
    logic        rom_start, mem_start, mem_to_ctrl, chan_wr, reply_valid;
    logic [7:0]  code_word, data_word, chan_rd_data, chan_data, reply_word, status_word;
    logic [6:0]  rom_addr;
    logic [12:0] chan_addr, ea;
    logic [7:0]  code, w0, wl, echo, ed, stat, ns, errs, act, rnd_code;
    logic [3:0]  m1, m2;
    logic [31:0] r;
    logic        e_rom, e_mem, e_wr, e_rep, busy, live;
    int          nw, n_errors, total_checks, seed;

    remote_unit_command_decoder u_remote_unit_command_decoder (.core_clk(core_clk),
        .rst_n(rst_n), .code_valid(code_valid), .code_word(code_word), .addr_ok(addr_ok),
        .addr_invalid(addr_invalid), .code_invalid(code_invalid), .parity_err(parity_err),
        .data_valid(data_valid), .data_word(data_word), .msg_end(msg_end),
        .encode_ok(encode_ok), .chan_rd_data(chan_rd_data), .rx_a(rx_a), .rx_b(rx_b),
        .tx_a(tx_a), .tx_b(tx_b), .rom_start(rom_start), .rom_addr(rom_addr),
        .mem_start(mem_start), .mem_to_ctrl(mem_to_ctrl), .chan_wr(chan_wr),
        .chan_addr(chan_addr), .chan_data(chan_data), .reply_valid(reply_valid),
        .reply_word(reply_word), .status_word(status_word));
    bus_control_unit_model u_bus_control_unit_model (.core_clk(core_clk),
        .code_valid(code_valid), .code_word(code_word), .addr_ok(addr_ok),
        .addr_invalid(addr_invalid), .code_invalid(code_invalid), .parity_err(parity_err),
        .data_valid(data_valid), .data_word(data_word), .msg_end(msg_end),
        .encode_ok(encode_ok));

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Channel register contents change every cycle
    always @(posedge core_clk) chan_rd_data <= 8'($random(seed));

    // Compare outputs with the prediction, then predict the next edge
    always @(posedge core_clk) begin
        if (live) begin
            check(13'(rom_start), 13'(e_rom));
            if (e_rom) check(13'(rom_addr), ea);
            check(13'(mem_start), 13'(e_mem));
            if (e_mem) check(13'(mem_to_ctrl), ea);
            check(13'(chan_wr), 13'(e_wr));
            if (e_wr) check(chan_addr, ea);
            if (e_wr) check(13'(chan_data), 13'(ed));
            check(13'(reply_valid), 13'(e_rep));
            if (e_rep) check(13'(reply_word), 13'(ed));
            check(13'(status_word), 13'(stat));
        end
        {e_rom, e_mem, e_wr, e_rep} = 4'h0;
        if (!rst_n) begin
            {busy, m1, m2} = 9'h000;
            stat = 8'he0;
            errs = 8'h00;
        end else begin
            // Activity bits pass two sync stages, then stick
            act = {m2, 4'h0};
            ns = stat | act;
            m2 = m1;
            m1 = {rx_a, rx_b, tx_a, tx_b};
            // Errors gather from one message end to the next, addressed or not
            errs = errs | {4'h0, parity_err, addr_invalid, code_invalid & code_valid, 1'b0};
            if (!busy && code_valid && addr_ok) begin
                busy = 1'b1;
                code = code_word;
                nw = 0;
                e_rom = !code[7];
                e_mem = code[7:6] == 2'b11;
                ea = e_rom ? 13'(code[6:0]) : 13'(code[5]);
            end else if (busy && data_valid) begin
                if (nw == 0) w0 = data_word;
                wl = data_word;
                nw++;
            end else if (msg_end) begin
                if (busy && code == 8'h01 && encode_ok && nw > 0) ns = w0 | act | errs;
                else ns = (ns & 8'hf1) | errs;
                if (busy) begin
                    if (code == 8'h06 && encode_ok) {e_rep, ed} = {1'b1, stat};
                    if (code == 8'h0d) {e_rep, ed} = {1'b1, echo};
                    if (code[7:5] == 3'b101 && encode_ok && nw > 0)
                        {e_rep, ed} = {1'b1, chan_rd_data};
                    if (code[7:5] == 3'b100 && encode_ok && nw > 1) begin
                        {e_wr, ed} = {1'b1, wl};
                        ea = {code[4:0], w0};
                    end
                    if (nw > 0) echo = wl;
                end
                busy = 1'b0;
                errs = 8'h00;
            end
            stat = ns;
        end
        live = rst_n;
    end

    initial begin
        seed = 49148;
        {n_errors, total_checks} = 0;
        {live, busy, rst_n} = 3'b000;
        {rx_a, rx_b, tx_a, tx_b} = 4'h0;
        chan_rd_data = 8'h00;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        r = $random(seed);
        // Power-on status, load, refused load, refused transmit
        u_bus_control_unit_model.send(8'h06, 5'h11, 0, 8'h00, 8'h00);
        u_bus_control_unit_model.send(8'h01, 5'h11, 1, r[7:0], 8'h00);
        u_bus_control_unit_model.send(8'h06, 5'h11, 0, 8'h00, 8'h00);
        u_bus_control_unit_model.send(8'h01, 5'h10, 1, ~r[7:0], 8'h00);
        u_bus_control_unit_model.send(8'h06, 5'h10, 0, 8'h00, 8'h00);
        // No-op with every error, then two status reads
        u_bus_control_unit_model.send(8'h00, 5'h1f, 0, 8'h00, 8'h00);
        u_bus_control_unit_model.send(8'h06, 5'h11, 0, 8'h00, 8'h00);
        u_bus_control_unit_model.send(8'h06, 5'h11, 0, 8'h00, 8'h00);
        // Override write, turnaround, read, short write, memory access both ways
        u_bus_control_unit_model.send({3'b100, r[4:0]}, 5'h11, 2, r[15:8], r[23:16]);
        u_bus_control_unit_model.send(8'h0d, 5'h11, 0, 8'h00, 8'h00);
        u_bus_control_unit_model.send({3'b101, r[9:5]}, 5'h11, 1, r[31:24], 8'h00);
        u_bus_control_unit_model.send({3'b100, r[9:5]}, 5'h11, 1, r[31:24], 8'h00);
        u_bus_control_unit_model.send({3'b110, r[4:0]}, 5'h11, 0, 8'h00, 8'h00);
        u_bus_control_unit_model.send({3'b111, r[9:5]}, 5'h11, 0, 8'h00, 8'h00);
        // Not addressed: ignored, though its errors still reach status
        u_bus_control_unit_model.send(8'h06, 5'h0f, 0, 8'h00, 8'h00);
        // Random traffic with modem activity bursts
        for (int k = 0; k < 40; k++) begin
            r = $random(seed);
            {rx_a, rx_b, tx_a, tx_b} <= (k % 8 == 0) ? r[3:0] : 4'h0;
            rnd_code = (r[15:8] == 8'h0d) ? 8'h06 : r[15:8];
            u_bus_control_unit_model.send(rnd_code, {3'b101, r[18:17]}, r[19] ? 2 : 1, r[27:20],
                                          r[31:24]);
        end
        repeat (3) @(posedge core_clk);
        results();
    end
endmodule // remote_unit_command_decoder_tb
